// ===== verilog/tss_supervisor.v
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "tss_defs.vh"

module tss_supervisor (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        enclosure_open,
    input  wire        battery_fault,
    input  wire        stored_tamper,
    output reg         stored_tamper_set,
    input  wire        reset_button_n,
    input  wire        fw_integrity_ok,
    input  wire [3:0]  iso_sense,
    input  wire [3:0]  select_button_n,
    output reg         tamper_test_drive,
    input  wire        tamper_test_echo,
    output reg  [3:0]  port_enable,
    output reg  [3:0]  led_selected,
    output reg         led_fail,
    output reg         led_tamper,
    output reg         normal_mode
);

    // Run order: INIT waits a few cycles, then INTEG, ISO and SEC each settle
    // for a fixed count and judge their input at the last cycle of the step.
    // A pass ends in NORMAL and any failed step ends in FAIL.
    // TAMPERED has no exit; only a full reset leaves it, and the
    // battery-backed latch then sends the supervisor straight back there.
    // Codes seven and above are unused and fall back to TAMPERED.
    localparam [2:0] ST_INIT     = 3'h0;
    localparam [2:0] ST_INTEG    = 3'h1;
    localparam [2:0] ST_ISO      = 3'h2;
    localparam [2:0] ST_SEC      = 3'h3;
    localparam [2:0] ST_NORMAL   = 3'h4;
    localparam [2:0] ST_FAIL     = 3'h5;
    localparam [2:0] ST_TAMPERED = 3'h6;

    // The counts are integers; they are cut to the counter width on purpose,
    // and both fit easily in sixteen bits.
    localparam integer SETTLE_INT = `TSS_SETTLE_CYC;
    localparam integer INIT_INT   = `TSS_INIT_CYC;
    localparam [15:0]  SETTLE_CYC = SETTLE_INT[15:0];
    localparam [15:0]  INIT_CYC   = INIT_INT[15:0];

    // Every pin enters through two flip-flops; only the second stage is read.
    // The reset value is each pin's idle level: a tamper pin that reset high
    // would look like an attack at the first edge and latch forever.
    // The buttons idle released and the echo idles low with its drive.
    wire [13:0] pin_raw = {enclosure_open, battery_fault, stored_tamper, reset_button_n,
                           fw_integrity_ok, tamper_test_echo, iso_sense, select_button_n};
    reg  [13:0] pin_meta;
    reg  [13:0] pin_sync;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 14'h060f;
            pin_sync <= 14'h060f;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // Names for the synchronised pins.
    wire       s_enclosure = pin_sync[13];
    wire       s_battery   = pin_sync[12];
    wire       s_stored    = pin_sync[11];
    wire       s_rst_btn_n = pin_sync[10];
    wire       s_fw_ok     = pin_sync[9];
    wire       s_echo      = pin_sync[8];
    wire [3:0] s_iso       = pin_sync[7:4];
    wire [3:0] s_sel_n     = pin_sync[3:0];

    // Supervisor state and the results of the last self-test run.
    reg         rst_btn_prev;
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [15:0] step_cnt;
    reg         tamper_seen;
    reg  [2:0]  tamper_log;
    reg  [2:0]  fail_cause;
    reg         test_passed;
    reg  [1:0]  select;
    reg         soft_start;

    // A request is new while ack is low, so each access acts exactly once.
    wire bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr      = bus_req & wb_we_i & wb_sel_i[0];
    wire btn_press   = rst_btn_prev & ~s_rst_btn_n;
    wire tamper_now  = s_enclosure | s_battery | s_stored;
    wire step_done   = (step_cnt == SETTLE_CYC);
    wire restart     = btn_press | soft_start;

    // Tamper record: each cause is sticky until the supervisor reset. The
    // stored cause returns from the battery-backed latch after any reset, so
    // neither a power cycle nor the reset button can hide an attack.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tamper_log  <= 3'h0;
            tamper_seen <= 1'b0;
        end else begin
            if (s_enclosure) tamper_log[`TSS_LOG_ENCLOSURE] <= 1'b1;
            if (s_battery)   tamper_log[`TSS_LOG_BATTERY]   <= 1'b1;
            if (s_stored)    tamper_log[`TSS_LOG_STORED]    <= 1'b1;
            if (tamper_now)  tamper_seen <= 1'b1;
        end
    end

    // The backup latch is set by a held level, so a missed edge cannot lose it.
    // It is never lowered here; only the battery-backed store could forget.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stored_tamper_set <= 1'b0;
        end else if (tamper_seen || tamper_now) begin
            stored_tamper_set <= 1'b1;
        end
    end

    // Next-state logic; tamper overrides every other transition.
    // Tamper is checked last so that no branch above can mask it.
    always @* begin
        next_state = state;
        case (state)
            ST_INIT: begin
                if (step_cnt == INIT_CYC) next_state = ST_INTEG;
            end
            ST_INTEG: begin
                if (step_done) next_state = s_fw_ok ? ST_ISO : ST_FAIL;
            end
            ST_ISO: begin
                if (step_done) next_state = (s_iso == 4'h0) ? ST_SEC : ST_FAIL;
            end
            ST_SEC: begin
                // A held select button means user control is stuck.
                if (step_done) begin
                    if (s_echo && (s_sel_n == 4'hf)) next_state = ST_NORMAL;
                    else next_state = ST_FAIL;
                end
            end
            ST_NORMAL: begin
                if (restart) next_state = ST_INTEG;
            end
            ST_FAIL: begin
                if (restart) next_state = ST_INTEG;
            end
            ST_TAMPERED: begin
                next_state = ST_TAMPERED;
            end
            default: begin
                next_state = ST_TAMPERED;
            end
        endcase
        if (tamper_now || tamper_seen) next_state = ST_TAMPERED;
    end

    // State register, step counter and reset-button edge tracking.
    // The step counter saturates so that a long stay in NORMAL cannot wrap it.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= ST_INIT;
            step_cnt     <= 16'h0000;
            rst_btn_prev <= 1'b1;
        end else begin
            state        <= next_state;
            rst_btn_prev <= s_rst_btn_n;
            if (next_state != state) step_cnt <= 16'h0000;
            else if (step_cnt != SETTLE_CYC) step_cnt <= step_cnt + 16'h0001;
        end
    end

    // Self-test result and cause of failure; a new run clears old causes.
    // Cause bits map integrity, isolation and security to bits 0, 1 and 2.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fail_cause  <= 3'h0;
            test_passed <= 1'b0;
        end else if (next_state == ST_INTEG && state != ST_INTEG) begin
            fail_cause  <= 3'h0;
            test_passed <= 1'b0;
        end else if (step_done) begin
            if (state == ST_INTEG && !s_fw_ok)       fail_cause[0] <= 1'b1;
            if (state == ST_ISO && s_iso != 4'h0)    fail_cause[1] <= 1'b1;
            if (state == ST_SEC && !(s_echo && (s_sel_n == 4'hf))) begin
                fail_cause[2] <= 1'b1;
            end
            if (state == ST_SEC && s_echo && (s_sel_n == 4'hf)) test_passed <= 1'b1;
        end
    end

    // The anti-tamper loop is exercised only during its own test step, so a
    // dead sensor loop shows as a missing echo and fails the test.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tamper_test_drive <= 1'b0;
        end else begin
            tamper_test_drive <= (next_state == ST_SEC);
        end
    end

    // Selection from front-panel buttons or software; lowest button wins.
    // A held button beats a software write, so the user keeps control.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            select <= `TSS_SEL_RESET;
        end else if (state == ST_NORMAL) begin
            if (!s_sel_n[0])      select <= 2'h0;
            else if (!s_sel_n[1]) select <= 2'h1;
            else if (!s_sel_n[2]) select <= 2'h2;
            else if (!s_sel_n[3]) select <= 2'h3;
            else if (bus_wr && wb_adr_i == `TSS_REG_SELECT) begin
                select <= wb_dat_i[`TSS_SEL_MSB:`TSS_SEL_LSB];
            end
        end
    end

    // Software start of a self-test run, a single-cycle request.
    // Registered to keep the restart off the bus decode's combinational path.
    // Only bit zero of the command word is decoded; other bits are ignored.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_start <= 1'b0;
        end else begin
            soft_start <= bus_wr && (wb_adr_i == `TSS_REG_TESTCMD)
                          && wb_dat_i[`TSS_CMD_START];
        end
    end

    // Front panel and fabric enables. The selection LED resets to computer
    // zero, so it is lit while reset is held and through power-up.
    // The fail LED also lights in TAMPERED, since that is a failed state too.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_enable  <= 4'h0;
            led_selected <= 4'h1;
            led_fail     <= 1'b0;
            led_tamper   <= 1'b0;
            normal_mode  <= 1'b0;
        end else begin
            led_selected <= 4'h1 << select;
            led_fail     <= (next_state == ST_FAIL) || (next_state == ST_TAMPERED);
            led_tamper   <= (next_state == ST_TAMPERED);
            normal_mode  <= (next_state == ST_NORMAL);
            if (next_state == ST_NORMAL) port_enable <= 4'h1 << select;
            else port_enable <= 4'h0;
        end
    end

    // The status word is built once, so the read select below stays plain.
    wire        test_busy   = (state != ST_NORMAL) && (state != ST_FAIL)
                              && (state != ST_TAMPERED);
    wire [31:0] status_word = {21'h0, fail_cause, test_busy, state == ST_TAMPERED,
                               state == ST_FAIL, test_passed, state == ST_NORMAL, state};

    // Wishbone classic slave: one wait state, unmapped addresses read zero.
    // The ack is registered, so it comes one cycle after the request is taken;
    // a write acts at that taking edge, which is safe because a classic master
    // holds the request until it sees the ack.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `TSS_RDATA_RESET;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= `TSS_RDATA_RESET;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `TSS_REG_SELECT: begin
                        wb_dat_o <= {30'h0, select};
                    end
                    `TSS_REG_STATUS: begin
                        wb_dat_o <= status_word;
                    end
                    `TSS_REG_TAMPER_LOG: begin
                        wb_dat_o <= {29'h0, tamper_log};
                    end
                    default: begin
                        wb_dat_o <= `TSS_RDATA_RESET;
                    end
                endcase
            end
        end
    end

endmodule

// ===== verilog/tss_defs.vh
`ifndef TSS_DEFS_VH
`define TSS_DEFS_VH

// Register byte offsets on the Wishbone bus.
`define TSS_REG_SELECT      8'h00
`define TSS_REG_STATUS      8'h04
`define TSS_REG_TESTCMD     8'h08
`define TSS_REG_TAMPER_LOG  8'h0c

// Field positions.
`define TSS_SEL_LSB         0
`define TSS_SEL_MSB         1
`define TSS_ST_STATE_LSB    0
`define TSS_ST_STATE_MSB    2
`define TSS_ST_NORMAL       3
`define TSS_ST_PASS         4
`define TSS_ST_FAIL         5
`define TSS_ST_TAMPER       6
`define TSS_ST_BUSY         7
`define TSS_ST_FAIL_INTEG   8
`define TSS_ST_FAIL_ISO     9
`define TSS_ST_FAIL_SEC     10
`define TSS_CMD_START       0
`define TSS_LOG_ENCLOSURE   0
`define TSS_LOG_BATTERY     1
`define TSS_LOG_STORED      2

// Reset values.
`define TSS_SEL_RESET       2'h0
`define TSS_RDATA_RESET     32'h0000_0000

// Timing: clock period and settle time of each self-test step, in ns.
`define TSS_CLK_NS          20
`define TSS_SETTLE_NS       2000
`define TSS_SETTLE_CYC      ((`TSS_SETTLE_NS + `TSS_CLK_NS - 1) / `TSS_CLK_NS)
`define TSS_INIT_CYC        4

`endif

// ===== testbench/tss_supervisor_asserts.sv
`timescale 1ns/1ps
module tss_supervisor_asserts (
    input wire        clk,
    input wire        rst_n,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_ack_o,
    input wire [31:0] wb_dat_o,
    input wire        enclosure_open,
    input wire        stored_tamper,
    input wire        stored_tamper_set,
    input wire        tamper_test_drive,
    input wire [3:0]  port_enable,
    input wire [3:0]  led_selected,
    input wire        led_fail,
    input wire        led_tamper,
    input wire        normal_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A fresh request, and a breach the supervisor has not yet answered.
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_breach;
        $rose(enclosure_open) || (stored_tamper && !led_tamper);
    endsequence
    a_ack_next: assert property (s_req |=> wb_ack_o)
        else $error("bus ack late");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack too long");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_iso_off: assert property (!normal_mode |-> port_enable == 4'h0)
        else $error("path open outside normal");
    a_sel_shown: assert property ($onehot(led_selected)
            && (!normal_mode || port_enable == led_selected))
        else $error("selection indication wrong");
    a_tamper_resp: assert property (s_breach |-> ##[1:4]
            (led_tamper && port_enable == 4'h0))
        else $error("tamper not answered");
    a_tamper_hold: assert property (led_tamper |=>
            led_tamper && led_fail && stored_tamper_set)
        else $error("tamper state left");
    a_test_dark: assert property (tamper_test_drive |-> !normal_mode)
        else $error("test drive in normal");
    a_fail_dark: assert property (led_fail |->
            !normal_mode && port_enable == 4'h0)
        else $error("fail shown while enabled");
endmodule
bind tss_supervisor tss_supervisor_asserts i_chk (
    .clk               (clk),
    .rst_n             (rst_n),
    .wb_cyc_i          (wb_cyc_i),
    .wb_stb_i          (wb_stb_i),
    .wb_ack_o          (wb_ack_o),
    .wb_dat_o          (wb_dat_o),
    .enclosure_open    (enclosure_open),
    .stored_tamper     (stored_tamper),
    .stored_tamper_set (stored_tamper_set),
    .tamper_test_drive (tamper_test_drive),
    .port_enable       (port_enable),
    .led_selected      (led_selected),
    .led_fail          (led_fail),
    .led_tamper        (led_tamper),
    .normal_mode       (normal_mode)
);

// ===== testbench/tss_partner.sv
`timescale 1ns/1ps
module tss_partner (
    input  wire        clk,
    input  wire        tamper_test_drive,
    input  wire        stored_tamper_set,
    input  wire [1:0]  tamp,
    input  wire [2:0]  fault,
    input  wire        press,
    input  wire [3:0]  btn,
    output logic       stored_tamper,
    output wire        enclosure_open,
    output wire        battery_fault,
    output wire        reset_button_n,
    output wire        fw_integrity_ok,
    output wire [3:0]  iso_sense,
    output wire [3:0]  select_button_n,
    output wire        tamper_test_echo
);
    // Battery-backed latch: set only, so it outlives any reset of the supervisor.
    initial stored_tamper = 1'b0;
    always @(posedge clk) begin
        if (stored_tamper_set) stored_tamper <= 1'b1;
    end
    // Sensors follow the bench's commands; each fault bit spoils one self-test step.
    assign enclosure_open   = tamp[0];
    assign battery_fault    = tamp[1];
    assign reset_button_n   = !press;
    assign fw_integrity_ok  = !fault[0];
    assign iso_sense        = {3'h0, fault[1]};
    assign select_button_n  = ~btn;
    assign tamper_test_echo = tamper_test_drive && !fault[2];
endmodule

// ===== testbench/tss_supervisor_tb_top.sv
`timescale 1ns/1ps
module tss_supervisor_tb_top;
    logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, press;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, rd;
    logic [2:0]  fault;
    logic [1:0]  tamp;
    logic [3:0]  btn;
    wire  [31:0] wb_dat_o;
    wire  [3:0]  iso_sense, select_button_n, port_enable, led_selected;
    wire         wb_ack_o, enclosure_open, battery_fault, stored_tamper, stored_tamper_set;
    wire         reset_button_n, fw_integrity_ok, tamper_test_drive, tamper_test_echo;
    wire         led_fail, led_tamper, normal_mode;
    int          n_fail, tests_run, k;

    tss_supervisor i_dut (
        .clk               (clk),
        .rst_n             (rst_n),
        .wb_cyc_i          (wb_cyc_i),
        .wb_stb_i          (wb_stb_i),
        .wb_we_i           (wb_we_i),
        .wb_adr_i          (wb_adr_i),
        .wb_sel_i          (wb_sel_i),
        .wb_dat_i          (wb_dat_i),
        .wb_dat_o          (wb_dat_o),
        .wb_ack_o          (wb_ack_o),
        .enclosure_open    (enclosure_open),
        .battery_fault     (battery_fault),
        .stored_tamper     (stored_tamper),
        .stored_tamper_set (stored_tamper_set),
        .reset_button_n    (reset_button_n),
        .fw_integrity_ok   (fw_integrity_ok),
        .iso_sense         (iso_sense),
        .select_button_n   (select_button_n),
        .tamper_test_drive (tamper_test_drive),
        .tamper_test_echo  (tamper_test_echo),
        .port_enable       (port_enable),
        .led_selected      (led_selected),
        .led_fail          (led_fail),
        .led_tamper        (led_tamper),
        .normal_mode       (normal_mode)
    );
    tss_partner i_far (
        .clk               (clk),
        .tamper_test_drive (tamper_test_drive),
        .stored_tamper_set (stored_tamper_set),
        .tamp              (tamp),
        .fault             (fault),
        .press             (press),
        .btn               (btn),
        .stored_tamper     (stored_tamper),
        .enclosure_open    (enclosure_open),
        .battery_fault     (battery_fault),
        .reset_button_n    (reset_button_n),
        .fw_integrity_ok   (fw_integrity_ok),
        .iso_sense         (iso_sense),
        .select_button_n   (select_button_n),
        .tamper_test_echo  (tamper_test_echo)
    );

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task tally_and_finish;
        $display("checks %0d errors %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task hang;
        n_fail++;
        $display("ERROR %0t: wait timed out", $time);
        tally_and_finish();
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Classic single cycle; held until ack is sampled high, data taken at that edge.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        if (n >= 50) hang();
    endtask

    // Waits for {tamper, fail, normal}; self-test takes about 310 cycles.
    task wait_ind(input logic [2:0] want);
        int n;
        for (n = 0; n < 600 && {led_tamper, led_fail, normal_mode} !== want; n++) @(posedge clk);
        if (n >= 600) hang();
    endtask

    initial begin
        {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, press} = 5'h00;
        {wb_adr_i, wb_sel_i, wb_dat_i, fault, tamp, btn} = {8'h00, 4'h1, 32'h0, 3'h0, 2'h0, 4'h0};
        n_fail = 0;
        tests_run = 0;
        repeat (10) @(posedge clk);
        chk(led_selected, 4'h1);
        chk(port_enable, 4'h0);
        rst_n <= 1'b1;
        wait_ind(3'b001);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h1c);
        chk(port_enable, 4'h1);
        bus(1'b1, 8'h00, 32'h2);
        bus(1'b1, 8'h04, 32'hff);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h2);
        chk(led_selected, 4'h4);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        // One failing step per pass: integrity, isolation, then security.
        for (k = 0; k < 3; k++) begin
            fault <= 3'b001 << k;
            press <= 1'b1;
            repeat (4) @(posedge clk);
            press <= 1'b0;
            wait_ind(3'b010);
            bus(1'b0, 8'h04, 32'h0);
            chk(rd, 32'h25 | (32'h100 << k));
            chk(led_selected, 4'h4);
            fault <= 3'h0;
            bus(1'b1, 8'h08, 32'h1);
            wait_ind(3'b001);
        end
        // A held front-panel button selects computer one and beats software.
        btn <= 4'h2;
        repeat (6) @(posedge clk);
        bus(1'b1, 8'h00, 32'h3);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h1);
        chk(led_selected, 4'h2);
        chk(port_enable, 4'h2);
        btn <= 4'h0;
        tamp <= 2'b11;
        wait_ind(3'b110);
        bus(1'b0, 8'h0c, 32'h0);
        chk(rd[1:0], 2'b11);
        tamp <= 2'b00;
        bus(1'b1, 8'h08, 32'h1);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd[6], 1'b1);
        chk(port_enable, 4'h0);
        rst_n <= 1'b0;
        @(posedge clk);
        chk(led_selected, 4'h1);
        rst_n <= 1'b1;
        wait_ind(3'b110);
        bus(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h4);
        tally_and_finish();
    end
endmodule
